//--- rtl/serial_mode_pkg.sv
// Purpose: constants, states and field decode for the serial bit-count and mode control block
// Assumes: 100 MHz aclk, AXI4-Lite register access with 32-bit data
// Notes:   shared by the register front end and the shift engine
//
// What this block does
// - length code 000 means 8 bits, else 1-7
// - clock-sync reads of count give remaining bits
// - count changes only when guard written 0
// - bit 4 ignores writes, reads as 1
// - wait bit adds two low transfer clocks
// - order bit 0 shifts most significant first
package serial_mode_pkg;

  // ****************************************************************
  // register map and field positions
  // ****************************************************************
  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  ADDR_MODE_CTL = 4'h0;
  localparam logic [3:0]  ADDR_DATA     = 4'h4;
  localparam logic [3:0]  ADDR_FORMAT   = 4'h8;
  localparam int          CNT_LSB       = 0;
  localparam int          CNT_MSB       = 2;
  localparam int          GUARD_BIT     = 3;
  localparam int          SPARE_BIT     = 4;
  localparam int          RSVD_BIT      = 5;
  localparam int          WAIT_BIT      = 6;
  localparam int          ORDER_BIT     = 7;
  localparam int          TWO_WIRE_BIT  = 0;
  localparam int          ACK_BIT       = 1;
  localparam int          BUSY_BIT      = 8;
  localparam logic [2:0]  CNT_RESET     = 3'h0;
  localparam logic [7:0]  DATA_RESET    = 8'h00;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          HALF_BIT_NS   = 40;
  localparam int          HALF_CYCLES   = (HALF_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          WAIT_CLOCKS   = 2;
  localparam int          WAIT_HALVES   = 2 * WAIT_CLOCKS;
  localparam logic [3:0]  FULL_FRAME    = 4'h8;

  // ****************************************************************
  // shift engine states
  // ****************************************************************
  typedef enum logic [5:0] {
    ST_IDLE     = 6'b00_0001,
    ST_LOW      = 6'b00_0010,
    ST_HIGH     = 6'b00_0100,
    ST_WAIT     = 6'b00_1000,
    ST_ACK_LOW  = 6'b01_0000,
    ST_ACK_HIGH = 6'b10_0000
  } shift_state_t;

  // frame length in bits from the 3-bit length code
  function automatic logic [3:0] frame_len(input logic [2:0] code);
    frame_len = (code == 3'h0) ? FULL_FRAME : {1'b0, code};
  endfunction

endpackage

//--- rtl/shift_ctl_if.sv
// Purpose: carrier between register front end and shift engine
// Assumes: both ends on aclk
// Notes:   start is a one-cycle pulse
`timescale 1ns/10ps
interface shift_ctl_if;
  logic       start;
  logic [2:0] len_code;
  logic       wait_en;
  logic       lsb_first;
  logic       two_wire;
  logic [7:0] tx_byte;
  logic       busy;
  logic [3:0] remaining;
  logic [7:0] rx_byte;
  logic       ack_bit;

  modport regs (output start, len_code, wait_en, lsb_first, two_wire, tx_byte,
                input  busy, remaining, rx_byte, ack_bit);
  modport engine (input  start, len_code, wait_en, lsb_first, two_wire, tx_byte,
                  output busy, remaining, rx_byte, ack_bit);
endinterface

//--- rtl/serial_shift_engine.sv
// Purpose: shifts one frame on the serial clock and data lines
// Assumes: start only taken while idle
// Notes:   data pin is open-drain style, enable low while driving
`timescale 1ns/10ps
module serial_shift_engine
  import serial_mode_pkg::*;
#(
  parameter int HALF = HALF_CYCLES
) (
  input  wire logic   aclk,
  input  wire logic   aresetn,
  shift_ctl_if.engine ctl,
  output logic        serial_clk_q,
  output logic        data_out_q,
  output logic        data_oe_n_q,
  input  wire logic   data_in
);

  shift_state_t state_q, state_d;
  logic [7:0]   div_q, div_d;
  logic [3:0]   bits_q, bits_d;
  logic [2:0]   wcnt_q, wcnt_d;
  logic [7:0]   sh_q, sh_d;
  logic         order_q, order_d;
  logic         sclk_d, sdo_d, oe_n_d, ack_q, ack_d;
  logic         tick;
  logic [7:0]   sh_in, first_load;
  logic [3:0]   len;

  assign tick = (div_q == 8'(HALF - 1));
  assign len  = frame_len(ctl.len_code);
  assign ctl.busy      = (state_q != ST_IDLE);
  assign ctl.remaining = bits_q;
  assign ctl.rx_byte   = sh_q;
  assign ctl.ack_bit   = ack_q;

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    div_d   = tick ? 8'h00 : div_q + 8'h01;
    bits_d  = bits_q;
    wcnt_d  = wcnt_q;
    sh_d    = sh_q;
    order_d = order_q;
    sclk_d  = serial_clk_q;
    sdo_d   = data_out_q;
    oe_n_d  = data_oe_n_q;
    ack_d   = ack_q;
    first_load = ctl.tx_byte << (4'h8 - len); // msb-first short frames start at bit len-1
    sh_in   = order_q ? {data_in, sh_q[7:1]} : {sh_q[6:0], data_in};
    unique case (state_q)
      ST_IDLE: begin
        div_d  = 8'h00;
        sclk_d = 1'b1;
        oe_n_d = 1'b1;
        if (ctl.start) begin
          state_d = ST_LOW;
          bits_d  = len;
          order_d = ctl.lsb_first;
          sh_d    = ctl.lsb_first ? ctl.tx_byte : first_load;
          sdo_d   = ctl.lsb_first ? ctl.tx_byte[0] : first_load[7];
          sclk_d  = 1'b0;
          oe_n_d  = 1'b0;
        end
      end
      ST_LOW: begin
        if (tick) begin
          state_d = ST_HIGH;
          sclk_d  = 1'b1;
        end
      end
      ST_HIGH: begin
        if (tick) begin
          sh_d   = sh_in;
          bits_d = bits_q - 4'h1;
          sclk_d = 1'b0;
          sdo_d  = order_q ? sh_in[0] : sh_in[7];
          if (bits_q == 4'h1) begin
            wcnt_d = 3'(WAIT_HALVES - 1);
            if (ctl.wait_en) begin
              state_d = ST_WAIT;
            end else if (ctl.two_wire) begin
              state_d = ST_ACK_LOW;
              oe_n_d  = 1'b1;
            end else begin
              state_d = ST_IDLE;
            end
          end else begin
            state_d = ST_LOW;
          end
        end
      end
      ST_WAIT: begin
        if (tick) begin
          wcnt_d = wcnt_q - 3'h1;
          if (wcnt_q == 3'h0) begin
            state_d = ctl.two_wire ? ST_ACK_LOW : ST_IDLE;
            oe_n_d  = 1'b1;
          end
        end
      end
      ST_ACK_LOW: begin
        if (tick) begin
          state_d = ST_ACK_HIGH;
          sclk_d  = 1'b1;
        end
      end
      ST_ACK_HIGH: begin
        if (tick) begin
          state_d = ST_IDLE;
          ack_d   = data_in;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // ****************************************************************
  // state registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q      <= ST_IDLE;
      div_q        <= 8'h00;
      bits_q       <= 4'h0;
      wcnt_q       <= 3'h0;
      sh_q         <= DATA_RESET;
      order_q      <= 1'b0;
      serial_clk_q <= 1'b1;
      data_out_q   <= 1'b1;
      data_oe_n_q  <= 1'b1;
      ack_q        <= 1'b1;
    end else begin
      state_q      <= state_d;
      div_q        <= div_d;
      bits_q       <= bits_d;
      wcnt_q       <= wcnt_d;
      sh_q         <= sh_d;
      order_q      <= order_d;
      serial_clk_q <= sclk_d;
      data_out_q   <= sdo_d;
      data_oe_n_q  <= oe_n_d;
      ack_q        <= ack_d;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [7:0] wait_run_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || state_q != ST_WAIT) wait_run_q <= 8'h00;
    else wait_run_q <= wait_run_q + 8'h01;
  end

  AST_LEN_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_IDLE && ctl.start) |=> bits_q == frame_len($past(ctl.len_code)))
    else $error("frame length not loaded from code");
  AST_WAIT_LEN: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_WAIT && state_d != ST_WAIT) |-> (wait_run_q == 8'(WAIT_HALVES * HALF - 1) && !serial_clk_q))
    else $error("wait low period wrong length");
  AST_NO_WAIT: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_HIGH && tick && bits_q == 4'h1 && !ctl.wait_en && ctl.two_wire) |=> state_q == ST_ACK_LOW)
    else $error("acknowledge not back to back");
  AST_MSB_FIRST: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_IDLE && ctl.start && !ctl.lsb_first) |=> data_out_q == $past(first_load[7]))
    else $error("first bit not most significant");
  AST_LSB_FIRST: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_IDLE && ctl.start && ctl.lsb_first) |=> data_out_q == $past(ctl.tx_byte[0]))
    else $error("first bit not least significant");

endmodule

//--- rtl/serial_mode_ctl.sv
// Purpose: AXI4-Lite register front end for the serial bit-count and mode control
// Assumes: one write and one read outstanding at most
// Notes:   only byte lane 0 carries written register bits; format reads also return busy in bit 8
//
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
module serial_mode_ctl
  import serial_mode_pkg::*;
#(
  parameter int HALF = HALF_CYCLES
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   serial_clk,
  output logic                   serial_data_o,
  output logic                   serial_data_oe_n,
  input  wire logic              serial_data_i
);

  // checks without their own clock use these
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  shift_ctl_if ctl ();

  // register select codes
  localparam logic [1:0] SEL_CTL  = 2'h0;
  localparam logic [1:0] SEL_DATA = 2'h1;
  localparam logic [1:0] SEL_FMT  = 2'h2;
  localparam logic [1:0] SEL_NONE = 2'h3;

  // address decode shared by read and write paths
  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
    unique case (a)
      ADDR_MODE_CTL: reg_sel = SEL_CTL;
      ADDR_DATA:     reg_sel = SEL_DATA;
      ADDR_FORMAT:   reg_sel = SEL_FMT;
      default:       reg_sel = SEL_NONE;
    endcase
  endfunction

  // ****************************************************************
  // bus channel state
  // ****************************************************************
  logic              awready_q, awready_d, wready_q, wready_d;
  logic              aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0]       wdata_q, wdata_d;
  logic [3:0]        wstrb_q, wstrb_d;
  logic              bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]       rdata_q, rdata_d;
  logic              aw_take, w_take, ar_take, do_wr;

  // ****************************************************************
  // control registers
  // ****************************************************************
  logic [2:0] cnt_q, cnt_d;
  logic       wait_q, wait_d, order_q, order_d, two_wire_q, two_wire_d;
  logic [7:0] tx_q, tx_d;
  logic       start_q, start_d;
  logic [7:0] ctl_view;

  assign aw_take = s_axi_awvalid && awready_q;
  assign w_take  = s_axi_wvalid && wready_q;
  assign ar_take = s_axi_arvalid && arready_q;
  assign do_wr   = aw_have_q && w_have_q && !bvalid_q;

  assign ctl.start     = start_q;
  assign ctl.len_code  = cnt_q;
  assign ctl.wait_en   = wait_q;
  assign ctl.lsb_first = order_q;
  assign ctl.two_wire  = two_wire_q;
  assign ctl.tx_byte   = tx_q;

  // readback view: guard and spare read 1, reserved reads 0
  always_comb begin
    ctl_view                   = 8'h00;
    ctl_view[CNT_MSB:CNT_LSB]  = two_wire_q ? cnt_q : ctl.remaining[2:0];
    ctl_view[GUARD_BIT]        = 1'b1;
    ctl_view[SPARE_BIT]        = 1'b1;
    ctl_view[RSVD_BIT]         = 1'b0;
    ctl_view[WAIT_BIT]         = wait_q;
    ctl_view[ORDER_BIT]        = order_q;
  end

  // write channel handshakes and register updates
  always_comb begin
    aw_have_d  = aw_have_q || aw_take;
    w_have_d   = w_have_q || w_take;
    awaddr_d   = aw_take ? s_axi_awaddr : awaddr_q;
    wdata_d    = w_take ? s_axi_wdata : wdata_q;
    wstrb_d    = w_take ? s_axi_wstrb : wstrb_q;
    bvalid_d   = bvalid_q && !s_axi_bready;
    bresp_d    = bresp_q;
    cnt_d      = cnt_q;
    wait_d     = wait_q;
    order_d    = order_q;
    two_wire_d = two_wire_q;
    tx_d       = tx_q;
    start_d    = 1'b0;
    if (do_wr) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (reg_sel(awaddr_q) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      if (wstrb_q[0]) begin
        unique case (reg_sel(awaddr_q))
          SEL_CTL: begin
            if (!wdata_q[GUARD_BIT]) cnt_d = wdata_q[CNT_MSB:CNT_LSB];
            wait_d  = wdata_q[WAIT_BIT];
            order_d = wdata_q[ORDER_BIT];
          end
          SEL_DATA: begin
            if (!ctl.busy) begin
              tx_d    = wdata_q[7:0];
              start_d = 1'b1;
            end
          end
          SEL_FMT:  two_wire_d = wdata_q[TWO_WIRE_BIT];
          SEL_NONE: bresp_d = RESP_SLVERR;
        endcase
      end
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d  = !w_have_d && !bvalid_d;
  end

  // read channel: answer one cycle after the address is taken
  always_comb begin
    rvalid_d = rvalid_q && !s_axi_rready;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (ar_take) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      unique case (reg_sel(s_axi_araddr))
        SEL_CTL:  rdata_d = {24'h00_0000, ctl_view};
        SEL_DATA: rdata_d = {24'h00_0000, ctl.rx_byte};
        SEL_FMT:  rdata_d = {23'h00_0000, ctl.busy, 6'h00, ctl.ack_bit, two_wire_q};
        SEL_NONE: begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
    arready_d = !rvalid_d;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
      aw_have_q  <= 1'b0;
      w_have_q   <= 1'b0;
      awaddr_q   <= '0;
      wdata_q    <= 32'h0000_0000;
      wstrb_q    <= 4'h0;
      bvalid_q   <= 1'b0;
      bresp_q    <= RESP_OKAY;
      arready_q  <= 1'b0;
      rvalid_q   <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      rresp_q    <= RESP_OKAY;
      cnt_q      <= CNT_RESET;
      wait_q     <= 1'b0;
      order_q    <= 1'b0;
      two_wire_q <= 1'b0;
      tx_q       <= DATA_RESET;
      start_q    <= 1'b0;
    end else begin
      awready_q  <= awready_d;
      wready_q   <= wready_d;
      aw_have_q  <= aw_have_d;
      w_have_q   <= w_have_d;
      awaddr_q   <= awaddr_d;
      wdata_q    <= wdata_d;
      wstrb_q    <= wstrb_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      arready_q  <= arready_d;
      rvalid_q   <= rvalid_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
      cnt_q      <= cnt_d;
      wait_q     <= wait_d;
      order_q    <= order_d;
      two_wire_q <= two_wire_d;
      tx_q       <= tx_d;
      start_q    <= start_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // ****************************************************************
  // shift engine
  // ****************************************************************
  serial_shift_engine #(
    .HALF (HALF)
  ) u_engine (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .ctl          (ctl.engine),
    .serial_clk_q (serial_clk),
    .data_out_q   (serial_data_o),
    .data_oe_n_q  (serial_data_oe_n),
    .data_in      (serial_data_i)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_GUARD_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_wr && reg_sel(awaddr_q) == SEL_CTL && wdata_q[GUARD_BIT]) |=> cnt_q == $past(cnt_q))
    else $error("count changed with guard set");
  AST_GUARD_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_wr && reg_sel(awaddr_q) == SEL_CTL && wstrb_q[0] && !wdata_q[GUARD_BIT])
      |=> cnt_q == $past(wdata_q[CNT_MSB:CNT_LSB]))
    else $error("count not written with guard clear");
  AST_CTL_READ: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_take && reg_sel(s_axi_araddr) == SEL_CTL)
      |=> (s_axi_rdata[GUARD_BIT] && s_axi_rdata[SPARE_BIT] && s_axi_rvalid))
    else $error("guard or spare bit not read as one");
  AST_REMAIN: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_take && reg_sel(s_axi_araddr) == SEL_CTL && !two_wire_q)
      |=> s_axi_rdata[CNT_MSB:CNT_LSB] == $past(ctl.remaining[2:0]))
    else $error("count read does not show remaining bits");

  // answers drop once taken
  AST_WR_CLEAR: assert property (
    (s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
    else $error("write response not cleared");
  AST_RD_CLEAR: assert property (
    (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid)
    else $error("read data not cleared");

  // answers follow the transfer by one edge
  AST_WR_ANSWER: assert property (
    do_wr |=> s_axi_bvalid)
    else $error("write response late");
  AST_RD_ANSWER: assert property (
    ar_take |=> s_axi_rvalid)
    else $error("read data late");

  // no request taken while an answer waits
  AST_AW_BLOCK: assert property (
    s_axi_bvalid |-> !(s_axi_awready || s_axi_wready))
    else $error("write taken while response waits");
  AST_AR_BLOCK: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data waits");

  // unmapped writes are refused
  AST_UNMAPPED: assert property (
    (do_wr && reg_sel(awaddr_q) == SEL_NONE) |=> s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");

  // settings follow register writes
  AST_MODE_BITS: assert property (
    (do_wr && reg_sel(awaddr_q) == SEL_CTL && wstrb_q[0])
      |=> {order_q, wait_q} == $past(wdata_q[ORDER_BIT:WAIT_BIT]))
    else $error("wait or order bit not stored");
  AST_FMT_BIT: assert property (
    (do_wr && reg_sel(awaddr_q) == SEL_FMT && wstrb_q[0])
      |=> two_wire_q == $past(wdata_q[TWO_WIRE_BIT]))
    else $error("format bit not stored");

  // two-wire format reads the stored code
  AST_CODE_READ: assert property (
    (ar_take && reg_sel(s_axi_araddr) == SEL_CTL && two_wire_q)
      |=> s_axi_rdata[CNT_MSB:CNT_LSB] == $past(cnt_q))
    else $error("stored length code not read back");

  // a frame starts only from idle
  AST_START_IDLE: assert property (
    start_q |-> !ctl.busy)
    else $error("start while engine busy");

endmodule

//--- verification/serial_peer.sv
// Purpose: serial bus peer on the shared clock and data lines
// Assumes: line has a pull-up; peer pulls low whenever the line is released, until the clock has been high over 8 cycles
// Notes:   records bits in arrival order and the longest clock low stretch
`timescale 1ns/10ps
module serial_peer (
  input  wire logic aclk,
  input  wire logic clr,
  input  wire logic serial_clk,
  input  wire logic serial_data_o,
  input  wire logic serial_data_oe_n,
  output logic      serial_data_i,
  output logic [7:0] rx_bits_q,
  output logic [3:0] rx_cnt_q,
  output int         max_low_q
);
  logic clk_prev_q;
  logic in_frame_q;
  int   low_cnt_q;
  int   hi_cnt_q;

  // wired line: released with pull-up, peer acks low inside a frame
  assign serial_data_i = serial_data_oe_n ? !in_frame_q : serial_data_o;

  // bit capture at clock rise and low-period measurement
  always @(posedge aclk) begin
    clk_prev_q <= serial_clk;
    low_cnt_q  <= serial_clk ? 0 : low_cnt_q + 1;
    hi_cnt_q   <= serial_clk ? hi_cnt_q + 1 : 0;
    if (!serial_clk) begin
      in_frame_q <= 1'b1;
    end else if (hi_cnt_q > 8) begin
      in_frame_q <= 1'b0; // long high means idle again
    end
    if (!serial_clk && low_cnt_q + 1 > max_low_q) begin
      max_low_q <= low_cnt_q + 1;
    end
    if (serial_clk && !clk_prev_q && !serial_data_oe_n) begin
      rx_bits_q <= {rx_bits_q[6:0], serial_data_o};
      rx_cnt_q  <= rx_cnt_q + 4'h1;
    end
    if (clr) begin
      rx_bits_q <= 8'h00;
      rx_cnt_q  <= 4'h0;
      max_low_q <= 0;
    end
  end

  initial begin
    clk_prev_q = 1'b1;
    in_frame_q = 1'b0;
    low_cnt_q  = 0;
    hi_cnt_q   = 0;
  end
endmodule

//--- verification/testbench.sv
// Purpose: self-checking bench for the serial bit-count and mode control block
// Assumes: HALF set to 2 to keep frames short
// Notes:   registers reached over AXI4-Lite, peer model on the serial side
`timescale 1ns/10ps
module testbench;
  import serial_mode_pkg::*;
  localparam int H = 2;
  logic aclk, aresetn, clr;
  logic [3:0] awaddr, araddr, wstrb;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic sclk, sdo, soe_n, sdi;
  logic [7:0] rx_bits;
  logic [3:0] rx_cnt;
  int max_low, error_cnt, compares;
  integer seed;

  serial_mode_ctl #(.HALF(H)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_clk(sclk), .serial_data_o(sdo), .serial_data_oe_n(soe_n), .serial_data_i(sdi));
  serial_peer peer (.aclk(aclk), .clr(clr), .serial_clk(sclk), .serial_data_o(sdo),
    .serial_data_oe_n(soe_n), .serial_data_i(sdi), .rx_bits_q(rx_bits), .rx_cnt_q(rx_cnt),
    .max_low_q(max_low));

  // ****************************************************************
  // clock, compare, bus tasks
  // ****************************************************************
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_done, w_done;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    aw_done = 1'b0;
    w_done  = 1'b0;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready) begin awvalid <= 1'b0; aw_done = 1'b1; end
      if (!w_done && wready) begin wvalid <= 1'b0; w_done = 1'b1; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // bits as the peer sees them, first bit ends up highest
  function automatic logic [7:0] exp_bits(logic [7:0] tx, logic [3:0] n, logic lsb);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < n; i++) r = {r[6:0], lsb ? tx[i] : tx[n-1-i]};
    return r;
  endfunction

  task automatic test_done;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog: all tests take well under 20000 cycles
  initial begin
    #200000;
    error_cnt++;
    test_done;
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin : main
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  tx;
    logic [2:0]  code;
    logic        wt, ord, seen_mid;
    seed = 32'hcbcec602;
    error_cnt = 0; compares = 0; aresetn = 1'b0; clr = 1'b0;
    awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0000_0000; wstrb = 4'hf;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(ADDR_MODE_CTL, d, r); chk("mode reset", d, 32'h0000_0018);
    rd(4'hc, d, r); chk("unmapped rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    wr(4'hc, 32'h0000_00ff, r); chk("unmapped bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    $display("test reset and map done");
    // two-wire format reads back the stored length code
    wr(ADDR_FORMAT, 32'h0000_0001, r);
    for (int k = 0; k < 8; k++) begin
      code = k[2:0];
      wt   = (k < 4) ? k[0] : 1'($random(seed)); // corners first
      ord  = (k < 4) ? k[1] : 1'($random(seed));
      tx   = 8'($random(seed));
      wr(ADDR_MODE_CTL, {24'h0, ord, wt, 1'b0, 1'b1, 1'b0, code}, r);
      rd(ADDR_MODE_CTL, d, r); chk("mode readback", d, {24'h0, ord, wt, 3'b011, code});
      wr(ADDR_MODE_CTL, {24'h0, ord, wt, 2'b00, 1'b1, ~code}, r);
      rd(ADDR_MODE_CTL, d, r); chk("guarded count", d, {24'h0, ord, wt, 3'b011, code});
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
      wr(ADDR_DATA, {24'h0, tx}, r);
      repeat (4) @(posedge aclk);
      for (int p = 0; p < 200; p++) begin
        rd(ADDR_FORMAT, d, r);
        if (d[BUSY_BIT] !== 1'b1) break;
      end
      chk("ack bit", {31'h0, d[ACK_BIT]}, 32'h0000_0000);
      chk("frame bits", {28'h0, rx_cnt}, {28'h0, frame_len(code)});
      chk("frame data", {24'h0, rx_bits}, {24'h0, exp_bits(tx, frame_len(code), ord)});
      chk("low stretch", max_low, wt ? 5 * H : H);
    end
    $display("test two-wire frames done");
    // clock-sync: remaining count visible mid-frame, data loops back
    wr(ADDR_FORMAT, 32'h0000_0000, r);
    wr(ADDR_MODE_CTL, 32'h0000_0000, r);
    tx = 8'($random(seed));
    wr(ADDR_DATA, {24'h0, tx}, r);
    seen_mid = 1'b0;
    for (int p = 0; p < 60; p++) begin
      rd(ADDR_MODE_CTL, d, r);
      if (d[2:0] != 3'h0) seen_mid = 1'b1;
    end
    chk("remaining seen", {31'h0, seen_mid}, 32'h0000_0001);
    rd(ADDR_MODE_CTL, d, r); chk("remaining end", d, 32'h0000_0018);
    rd(ADDR_DATA, d, r); chk("sync rx data", d, {24'h0, tx});
    $display("test clock-sync frame done");
    test_done;
  end
endmodule
